//--- inc/gtap_pkg.sv
// constants for the global trigger algorithm processor: register map, field layout, timing
// assumes one 32-bit word per register on an AHB-Lite slave port
package gtap_pkg;
  localparam int          NCH          = 4;
  localparam int          CH_FWD       = 0;
  localparam int          CH_BARREL    = 1;
  localparam int          CH_TOF       = 2;
  localparam int          CH_START     = 3;
  localparam int          LAT_CYCLES   = 46;
  localparam int          PIPE_LEN     = LAT_CYCLES - 2;
  localparam int          FRAC_BITS    = 16;
  localparam int          NTRIG        = 32;
  localparam int          NOUT         = 30;
  localparam int          WIN_FIELD    = 8;
  localparam int          ROUTE_FIELD  = 8;
  localparam int          ROUTE_EN_BIT = 5;
  localparam logic [7:0]  A_WINLEN     = 8'h00;
  localparam logic [7:0]  A_COEF_TRK   = 8'h04;
  localparam logic [7:0]  A_COEF_EN    = 8'h08;
  localparam logic [7:0]  A_COEF_RAT   = 8'h0C;
  localparam logic [7:0]  A_THR_EQ     = 8'h10;
  localparam logic [7:0]  A_THR_TLOW   = 8'h14;
  localparam logic [7:0]  A_THR_THIGH  = 8'h18;
  localparam logic [7:0]  A_COND0      = 8'h20;
  localparam logic [7:0]  A_COND1      = 8'h24;
  localparam logic [7:0]  A_COND2      = 8'h28;
  localparam logic [7:0]  A_COND3      = 8'h2C;
  localparam logic [7:0]  A_TAG_CNT    = 8'h30;
  localparam logic [7:0]  A_TRIG       = 8'h34;
  localparam logic [2:0]  A_ROUTE_HI   = 3'b010;
  localparam logic [1:0]  HTRANS_NSEQ  = 2'b10;
  localparam logic [2:0]  HSIZE_WORD   = 3'b010;
  localparam logic [31:0] RST_WORD     = 32'h0000_0000;
endpackage

//--- core/gtap_core.sv
// global trigger algorithm processor: sliding-window conditioning, equation, trigger routing
// assumes upstream streams arrive on hclk from link logic, AHB-Lite single-word master
//
// Contract
// [RL1] each upstream processor sends one 32-bit variable per clock, up to sixteen.
// [RL2] everything runs on one clock, fully pipelined, one decision per cycle.
// [RL3] accepts forward/barrel energy, tof tracks, tagger min/max/count, start tracks.
// [RL4] variables are conditioned over several cycles before any equation uses them.
// [RL5] calorimeter energy sums are integrated over a programmable window.
// [RL6] integration uses a programmable-length delay line fed every cycle.
// [RL7] delay line and accumulator start at zero.
// [RL8] value entering the delay line is added to the accumulator same step.
// [RL9] value leaving the delay line is subtracted, giving exact window sum.
// [RL10] tof and start track counts use the same sliding-window accumulator.
// [RL11] conditioned integers are converted to single-precision float.
// [RL12] weighted sum of tracks, energy, and energy+1 over barrel+1, programmable coefs.
// [RL13] trigger only if result >= threshold, tagger min above, max below thresholds.
// [RL14] equation pipeline fixed latency 46 cycles from conditioned input to trigger.
// [RL15] leave room for more equations evaluated in parallel.
// [RL16] up to 32 triggers, each routable to any output position.
// [RL17] up to 30 trigger bits with programmable placement plus two clock outputs.
// [RL18] rewriting a window length flushes that channel's line and accumulator.
// [RL19] accumulators wide enough that a full window of max inputs cannot overflow.
//
// Implementation choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module gtap_core #(
  parameter int DEPTH = 16
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [31:0] forward_calo_energy,
  input  wire logic [31:0] barrel_calo_energy,
  input  wire logic [31:0] forward_tof_tracks,
  input  wire logic [31:0] start_tracks,
  input  wire logic [31:0] tagger_low_value,
  input  wire logic [31:0] tagger_high_value,
  input  wire logic [31:0] tagger_track_count,
  output logic      [29:0] trigger_out,
  output logic      [1:0]  trigger_clk_out
);
  localparam int WINW = $clog2(DEPTH) + 1;
  // [RL19] width guard
  localparam int ACCW = 32 + WINW;
  localparam int EQW  = 70;

  typedef struct packed {
    logic [gtap_pkg::NCH-1:0][DEPTH-1:0][31:0] line;
    logic [gtap_pkg::NCH-1:0][ACCW-1:0]        acc;
    logic [gtap_pkg::NCH-1:0][WINW-1:0]        win;
    logic [gtap_pkg::NCH-1:0][31:0]            flt;
    logic [31:0]                               c_trk;
    logic [31:0]                               c_en;
    logic [31:0]                               c_rat;
    logic [31:0]                               thr_eq;
    logic [31:0]                               thr_lo;
    logic [31:0]                               thr_hi;
    logic [31:0]                               tag_lo;
    logic [31:0]                               tag_hi;
    logic [31:0]                               tag_cnt;
    logic [EQW-1:0]                            eq;
    logic                                      tag_ok;
    logic [gtap_pkg::PIPE_LEN-1:0]             pipe;
    logic [gtap_pkg::NTRIG-1:0][5:0]           route;
    logic [29:0]                               trig;
    logic [1:0]                                clk_out;
    logic                                      wr_pend;
    logic [7:0]                                wr_addr;
    logic [31:0]                               hrdata;
    logic                                      hreadyout;
  } gtap_state_t;

  gtap_state_t s_q;
  gtap_state_t s_d;

  // truncating integer to float; fraction below 23 bits is dropped, not rounded
  function automatic logic [31:0] gtap_to_float(input logic [EQW-1:0] v);
    logic [7:0]     e;
    logic [EQW-1:0] n;
    e = 8'h00;
    n = v;
    for (int i = 0; i < EQW; i++) begin
      if (v[i]) begin
        e = 8'(i);
      end
    end
    n = v << (8'(EQW - 1) - e);
    if (v == '0) begin
      return 32'h0000_0000;
    end
    return {1'b0, 8'(e + 8'd127), n[EQW-2 -: 23]};
  endfunction

  logic [gtap_pkg::NCH-1:0][31:0] cin;
  assign cin[gtap_pkg::CH_FWD]    = forward_calo_energy;
  assign cin[gtap_pkg::CH_BARREL] = barrel_calo_energy;
  assign cin[gtap_pkg::CH_TOF]    = forward_tof_tracks;
  assign cin[gtap_pkg::CH_START]  = start_tracks;

  logic [gtap_pkg::NCH-1:0][31:0] tap;
  logic [gtap_pkg::NCH-1:0]       flush;
  logic [ACCW+31:0]               trk_t;
  logic [ACCW+31:0]               en_t;
  logic [ACCW:0]                  num_i;
  logic [ACCW:0]                  den_i;
  logic [ACCW+gtap_pkg::FRAC_BITS:0] quot;
  logic [ACCW+gtap_pkg::FRAC_BITS+32:0] rat_t;
  logic [ACCW+gtap_pkg::FRAC_BITS+34:0] sum_t;
  logic                           fire;
  logic [gtap_pkg::NTRIG-1:0]     tvec;
  logic                           addr_ok;
  logic [7:0]                     ra;
  logic [WINW-1:0]                wv;

  always_comb begin
    s_d     = s_q;
    tap     = '0;
    flush   = '0;
    trk_t   = '0;
    en_t    = '0;
    num_i   = '0;
    den_i   = '0;
    quot    = '0;
    rat_t   = '0;
    sum_t   = '0;
    fire    = 1'b0;
    tvec    = '0;
    addr_ok = 1'b0;
    ra      = 8'h00;
    wv      = '0;

    // register writes land in the data phase
    if (s_q.wr_pend) begin
      unique case (s_q.wr_addr)
        gtap_pkg::A_WINLEN: begin
          for (int c = 0; c < gtap_pkg::NCH; c++) begin
            wv = hwdata[c*gtap_pkg::WIN_FIELD +: WINW];
            if (wv > WINW'(DEPTH)) begin
              wv = WINW'(DEPTH);
            end
            // [RL18] flush on length change
            flush[c]   = (wv != s_q.win[c]);
            s_d.win[c] = wv;
          end
        end
        gtap_pkg::A_COEF_TRK:  s_d.c_trk  = hwdata;
        gtap_pkg::A_COEF_EN:   s_d.c_en   = hwdata;
        gtap_pkg::A_COEF_RAT:  s_d.c_rat  = hwdata;
        gtap_pkg::A_THR_EQ:    s_d.thr_eq = hwdata;
        gtap_pkg::A_THR_TLOW:  s_d.thr_lo = hwdata;
        gtap_pkg::A_THR_THIGH: s_d.thr_hi = hwdata;
        default: begin
          if (s_q.wr_addr[7:5] == gtap_pkg::A_ROUTE_HI) begin
            for (int k = 0; k < 4; k++) begin
              s_d.route[{s_q.wr_addr[4:2], 2'(k)}] = hwdata[k*gtap_pkg::ROUTE_FIELD +: 6];
            end
          end
        end
      endcase
    end

    // [RL4] [RL5] [RL10] four identical sliding-window integrators
    for (int c = 0; c < gtap_pkg::NCH; c++) begin
      // [RL9] oldest sample leaves here; zero length passes the input straight back out
      tap[c] = (s_q.win[c] == '0) ? cin[c] : s_q.line[c][s_q.win[c] - WINW'(1)];
      // [RL6] [RL8] push every cycle, add on entry
      s_d.line[c] = {s_q.line[c][DEPTH-2:0], cin[c]};
      s_d.acc[c]  = s_q.acc[c] + ACCW'(cin[c]) - ACCW'(tap[c]);
      if (flush[c]) begin
        s_d.line[c] = '0;
        s_d.acc[c]  = '0;
      end
      // [RL11] conditioned value as float, readable by software
      s_d.flt[c] = gtap_to_float(EQW'(s_q.acc[c]));
    end
    // [RL3] raw tagger values taken alongside the conditioned sums
    s_d.tag_lo  = tagger_low_value;
    s_d.tag_hi  = tagger_high_value;
    s_d.tag_cnt = tagger_track_count;

    // [RL12] coefficients are unsigned 16.16 fixed point
    trk_t = s_q.acc[gtap_pkg::CH_TOF] * s_q.c_trk;
    en_t  = s_q.acc[gtap_pkg::CH_FWD] * s_q.c_en;
    num_i = {1'b0, s_q.acc[gtap_pkg::CH_FWD]} + (ACCW+1)'(1);
    den_i = {1'b0, s_q.acc[gtap_pkg::CH_BARREL]} + (ACCW+1)'(1);
    // single-stage divider: simple but sets the clock ceiling
    quot  = {num_i, 16'h0000} / den_i;
    rat_t = quot * s_q.c_rat;
    sum_t = ($bits(sum_t))'(trk_t) + ($bits(sum_t))'(en_t) + ($bits(sum_t))'(rat_t >> gtap_pkg::FRAC_BITS);
    s_d.eq = sum_t[gtap_pkg::FRAC_BITS +: EQW];
    // [RL13] tagger window
    s_d.tag_ok = (s_q.tag_lo > s_q.thr_lo) && (s_q.tag_hi < s_q.thr_hi);

    // [RL11] [RL13] positive floats compare as unsigned integers
    fire = s_q.tag_ok && (gtap_to_float(s_q.eq) >= s_q.thr_eq);
    // [RL2] [RL14] delay line pads to the fixed latency
    s_d.pipe = {s_q.pipe[gtap_pkg::PIPE_LEN-2:0], fire};

    // [RL15] spare trigger slots for further equations
    tvec[0] = s_q.pipe[gtap_pkg::PIPE_LEN-1];
    // [RL16] [RL17] each output position picks any trigger
    for (int p = 0; p < gtap_pkg::NOUT; p++) begin
      s_d.trig[p] = s_q.route[p][gtap_pkg::ROUTE_EN_BIT] & tvec[s_q.route[p][4:0]];
    end
    // [RL17] two clock outputs at half rate, opposite phase
    s_d.clk_out = {s_q.clk_out[0], ~s_q.clk_out[0]};

    // bus address phase; read mux looks at post-write state so read-after-write sees new data
    addr_ok       = hsel && hready && (htrans == gtap_pkg::HTRANS_NSEQ);
    s_d.wr_pend   = addr_ok && hwrite && (hsize == gtap_pkg::HSIZE_WORD);
    s_d.wr_addr   = {haddr[7:2], 2'b00};
    s_d.hreadyout = 1'b1;
    if (addr_ok && !hwrite) begin
      ra         = {haddr[7:2], 2'b00};
      s_d.hrdata = gtap_pkg::RST_WORD;
      unique case (ra)
        gtap_pkg::A_WINLEN: begin
          for (int c = 0; c < gtap_pkg::NCH; c++) begin
            s_d.hrdata[c*gtap_pkg::WIN_FIELD +: WINW] = s_d.win[c];
          end
        end
        gtap_pkg::A_COEF_TRK:  s_d.hrdata = s_d.c_trk;
        gtap_pkg::A_COEF_EN:   s_d.hrdata = s_d.c_en;
        gtap_pkg::A_COEF_RAT:  s_d.hrdata = s_d.c_rat;
        gtap_pkg::A_THR_EQ:    s_d.hrdata = s_d.thr_eq;
        gtap_pkg::A_THR_TLOW:  s_d.hrdata = s_d.thr_lo;
        gtap_pkg::A_THR_THIGH: s_d.hrdata = s_d.thr_hi;
        gtap_pkg::A_COND0:     s_d.hrdata = s_q.flt[0];
        gtap_pkg::A_COND1:     s_d.hrdata = s_q.flt[1];
        gtap_pkg::A_COND2:     s_d.hrdata = s_q.flt[2];
        gtap_pkg::A_COND3:     s_d.hrdata = s_q.flt[3];
        gtap_pkg::A_TAG_CNT:   s_d.hrdata = s_q.tag_cnt;
        gtap_pkg::A_TRIG:      s_d.hrdata = {2'b00, s_q.trig};
        default: begin
          if (ra[7:5] == gtap_pkg::A_ROUTE_HI) begin
            for (int k = 0; k < 4; k++) begin
              s_d.hrdata[k*gtap_pkg::ROUTE_FIELD +: 6] = s_d.route[{ra[4:2], 2'(k)}];
            end
          end
        end
      endcase
    end
  end

  // [RL7] everything, delay lines and sums included, clears to zero except clk_out (loads 01) and hreadyout (loads 1)
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q           <= '0;
      s_q.clk_out   <= 2'b01;
      s_q.hreadyout <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata          = s_q.hrdata;
  assign hreadyout       = s_q.hreadyout;
  assign hresp           = 1'b0;
  assign trigger_out     = s_q.trig;
  assign trigger_clk_out = s_q.clk_out;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic wr_win;
  logic past_ok;
  assign wr_win = s_q.wr_pend && (s_q.wr_addr == gtap_pkg::A_WINLEN);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      past_ok <= 1'b0;
    end else begin
      past_ok <= 1'b1;
    end
  end

  flush_zero_a: assert property (wr_win && (hwdata[4:0] != s_q.win[0]) && (hwdata[4:0] <= WINW'(DEPTH)) // [RL18]
      |=> s_q.acc[0] == '0)
    else $error("window rewrite did not clear sum");
  acc_step_a: assert property (past_ok && !$past(wr_win) |-> // [RL8]
      s_q.acc[1] == $past(s_q.acc[1]) + ACCW'($past(barrel_calo_energy)) - ACCW'($past(tap[1])))
    else $error("barrel sum not updated by entry and exit");
  win_zero_a: assert property (s_q.win[2] == '0 && !wr_win ##1 s_q.win[2] == '0 && !wr_win // [RL9]
      |=> s_q.acc[2] == '0)
    else $error("zero-length window left a residue");
  win_one_a: assert property (s_q.win[3] == WINW'(1) && !wr_win |=> // [RL10]
      s_q.acc[3] == ACCW'($past(start_tracks)) || s_q.acc[3] == '0)
    else $error("one-cycle window does not hold last sample");
  lat_fix_a: assert property (past_ok && fire |-> ##44 s_q.pipe[gtap_pkg::PIPE_LEN-1]) // [RL14]
    else $error("equation fire lost in latency pipe");
  tag_gate_a: assert property (s_q.tag_lo <= s_q.thr_lo |=> !s_q.tag_ok ##1 !s_q.pipe[0]) // [RL13]
    else $error("trigger formed with tagger minimum too low");
  route_off_a: assert property (!s_q.route[0][gtap_pkg::ROUTE_EN_BIT] && !s_d.route[0][gtap_pkg::ROUTE_EN_BIT]
      |=> !trigger_out[0]) // [RL16]
    else $error("disabled output position drove a trigger");
  // past_ok keeps the release edge, whose history is reset state, out of the check
  clk_pair_a: assert property (past_ok |-> trigger_clk_out[0] != trigger_clk_out[1] && // [RL17]
      trigger_clk_out != $past(trigger_clk_out))
    else $error("clock outputs not toggling in opposite phase");
  bus_ok_a: assert property (hreadyout && !hresp) // [RL2]
    else $error("slave stalled or errored");
  pipe_step_a: assert property (past_ok |-> // [RL2]
      s_q.pipe[gtap_pkg::PIPE_LEN-1:1] == $past(s_q.pipe[gtap_pkg::PIPE_LEN-2:0]))
    else $error("decision pipe did not advance one stage");
endmodule

//--- tb/gtap_stream_src.sv
// upstream stream source: one 32-bit word per stream on every clock
// assumes the bench sets the wanted values; they appear one clock later
`timescale 1ns/1ps
module gtap_stream_src (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [31:0] val [7],
  output logic      [31:0] stream [7]
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stream <= '{default: 32'h0000_0000};
    end else begin
      stream <= val;
    end
  end
endmodule

//--- tb/gtap_bench.sv
// self-checking bench for gtap_core: bus tasks, windows, equation, routing
// assumes one slave on the bus and the stream source adding one clock
`timescale 1ns/1ps
module gtap_bench;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'b000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [31:0] s_in [7] = '{default: 32'h0000_0000};
  logic [31:0] s_out [7];
  logic [29:0] trigger_out;
  logic [1:0]  trigger_clk_out;
  int          mismatches = 0;
  int          samples_checked = 0;
  // tracks, fwd energy, barrel, track/energy/ratio coef, tagger low, high
  int          cs [5][8] = '{'{10, 0, 0, 65536, 0, 0, 5, 9}, '{9, 0, 0, 65536, 0, 0, 5, 9},
                             '{10, 0, 0, 65536, 0, 0, 4, 9}, '{10, 0, 0, 65536, 0, 0, 5, 10},
                             '{0, 3, 1, 0, 32768, 294912, 5, 9}};

  always #2.5 hclk = ~hclk;

  gtap_stream_src i_gtap_stream_src (.hclk(hclk), .hresetn(hresetn), .val(s_in), .stream(s_out));

  gtap_core i_gtap_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .forward_calo_energy(s_out[0]), .barrel_calo_energy(s_out[1]),
    .forward_tof_tracks(s_out[2]), .start_tracks(s_out[3]), .tagger_low_value(s_out[4]),
    .tagger_high_value(s_out[5]), .tagger_track_count(s_out[6]), .trigger_out(trigger_out),
    .trigger_clk_out(trigger_clk_out));

  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("BAD at %0t got %h exp %h", $time, got, exp);
      mismatches++;
    end
  endtask

  // a lost handshake ends the run rather than hanging it
  task automatic edge_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) begin
      mismatches++;
      results();
    end
  endtask

  task automatic bus(input logic is_wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    hwrite <= is_wr;
    hsize  <= gtap_pkg::HSIZE_WORD;
    htrans <= gtap_pkg::HTRANS_NSEQ;
    edge_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    edge_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0000_0000, rd);
    chk(rd, exp);
  endtask

  // truncating integer to single float, exact for the small sums used here
  function automatic logic [31:0] fl(input logic [31:0] x);
    int e;
    e = 31;
    if (x == 32'h0000_0000) return 32'h0000_0000;
    while (!x[e]) e--;
    return {1'b0, 8'(127 + e), 23'((x << (31 - e)) >> 8)};
  endfunction

  function automatic logic exp_trig(input int i);
    longint r;
    r = longint'(cs[i][0]) * cs[i][3] + longint'(cs[i][1]) * cs[i][4];
    r = (r + ((((longint'(cs[i][1]) + 1) <<< 16) / (cs[i][2] + 1) * cs[i][5]) >>> 16)) >>> 16;
    return r >= 10 && cs[i][6] > 4 && cs[i][7] < 10;
  endfunction

  initial begin
    logic [31:0] c;
    int          n;
    logic        e;
    repeat (20) @(posedge hclk);
    chk(32'(trigger_clk_out), 32'h0000_0001);
    chk(32'(trigger_out), 32'h0000_0000);
    hresetn <= 1'b1;
    c = 32'(trigger_clk_out);
    repeat (4) begin
      @(posedge hclk);
      #1;
      chk(32'(trigger_clk_out), ~c & 32'h0000_0003);
      c = 32'(trigger_clk_out);
    end
    // bus requests start on a clock edge, not mid-cycle
    @(posedge hclk);
    $display("test reset done");
    rdc(gtap_pkg::A_COND0, 32'h0000_0000);
    rdc(gtap_pkg::A_COEF_EN, 32'h0000_0000);
    wr(gtap_pkg::A_COEF_TRK, 32'h0001_8000);
    rdc(gtap_pkg::A_COEF_TRK, 32'h0001_8000);
    wr(8'h38, 32'hFFFF_FFFF);
    rdc(8'h38, 32'h0000_0000);
    $display("test registers done");
    s_in[0] <= 32'h0000_0007;
    s_in[1] <= 32'h0000_0005;
    s_in[2] <= 32'h0000_0006;
    s_in[3] <= 32'h0000_0009;
    s_in[6] <= 32'h0000_0123;
    wr(gtap_pkg::A_WINLEN, 32'h0102_0304);
    repeat (30) @(posedge hclk);
    for (int k = 0; k < 4; k++) begin
      rdc(8'(gtap_pkg::A_COND0 + 4 * k), fl(32'(4 - k) * s_in[k]));
    end
    wr(gtap_pkg::A_WINLEN, 32'h0102_0302);
    repeat (30) @(posedge hclk);
    rdc(gtap_pkg::A_COND0, fl(32'h0000_000E));
    s_in[0] <= 32'hFFFF_FFFF;
    wr(gtap_pkg::A_WINLEN, 32'h0102_0314);
    repeat (40) @(posedge hclk);
    rdc(gtap_pkg::A_COND0, 32'h517F_FFFF);
    rdc(gtap_pkg::A_TAG_CNT, 32'h0000_0123);
    wr(gtap_pkg::A_WINLEN, 32'h0000_0000);
    repeat (20) @(posedge hclk);
    rdc(gtap_pkg::A_COND0, 32'h0000_0000);
    $display("test windows done");
    wr(gtap_pkg::A_WINLEN, 32'h0101_0101);
    wr(gtap_pkg::A_THR_EQ, 32'h4120_0000);
    wr(gtap_pkg::A_THR_TLOW, 32'h0000_0004);
    wr(gtap_pkg::A_THR_THIGH, 32'h0000_000A);
    wr(8'h40, 32'h0000_2120);
    wr(8'h5C, 32'h0000_2000);
    for (int i = 0; i < 5; i++) begin
      s_in[4] <= 32'h0000_0000;
      wr(gtap_pkg::A_COEF_TRK, 32'(cs[i][3]));
      wr(gtap_pkg::A_COEF_EN, 32'(cs[i][4]));
      wr(gtap_pkg::A_COEF_RAT, 32'(cs[i][5]));
      repeat (60) @(posedge hclk);
      e = exp_trig(i);
      s_in[2] <= 32'(cs[i][0]);
      s_in[0] <= 32'(cs[i][1]);
      s_in[1] <= 32'(cs[i][2]);
      s_in[4] <= 32'(cs[i][6]);
      s_in[5] <= 32'(cs[i][7]);
      n = 0;
      do begin
        @(posedge hclk);
        #1;
        n++;
      end while (trigger_out[0] !== 1'b1 && n < 60);
      // a quiet case waits out the whole latency so a late false trigger is seen
      if (e) chk(32'(n), 32'h0000_0030);
      chk(32'(trigger_out), e ? 32'h2000_0001 : 32'h0000_0000);
      @(posedge hclk);
      rdc(gtap_pkg::A_TRIG, e ? 32'h2000_0001 : 32'h0000_0000);
      $display("test equation case %0d done", i);
    end
    results();
  end
endmodule
